/* File: verilog/ald_pkg.sv */
package ald_pkg;

    localparam int ALD_DW = 8;

    // Opcode high nibbles of the two-operand groups
    localparam logic [3:0] HI_ADD = 4'h2;
    localparam logic [3:0] HI_ADDC = 4'h3;
    localparam logic [3:0] HI_SUBB = 4'h9;
    localparam logic [3:0] HI_ORL = 4'h4;
    localparam logic [3:0] HI_ANL = 4'h5;
    localparam logic [3:0] HI_XRL = 4'h6;

    // Opcode low nibbles selecting the operand source
    localparam logic [3:0] LO_DIR_ACC = 4'h2;
    localparam logic [3:0] LO_DIR_IMM = 4'h3;
    localparam logic [3:0] LO_IMM = 4'h4;
    localparam logic [3:0] LO_DIR = 4'h5;
    localparam logic [3:0] LO_IND0 = 4'h6;
    localparam logic [3:0] LO_IND1 = 4'h7;

    // Single-byte accumulator opcodes
    localparam logic [7:0] OPC_CLR = 8'hE4;
    localparam logic [7:0] OPC_CPL = 8'hF4;
    localparam logic [7:0] OPC_SWAP = 8'hC4;
    localparam logic [7:0] OPC_RL = 8'h23;
    localparam logic [7:0] OPC_RLC = 8'h33;
    localparam logic [7:0] OPC_RR = 8'h03;
    localparam logic [7:0] OPC_RRC = 8'h13;

    // Lengths in bytes and execution times in system clock cycles
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;
    localparam logic [2:0] CYC_SHORT = 3'h2;
    localparam logic [2:0] CYC_LONG = 3'h4;
    localparam logic [2:0] CNT_LAST = 3'h1;

    typedef enum logic [3:0] {
        ALD_OP_NONE = 4'h0,
        ALD_OP_ADD = 4'h1,
        ALD_OP_ADDC = 4'h2,
        ALD_OP_SUBB = 4'h3,
        ALD_OP_AND = 4'h4,
        ALD_OP_OR = 4'h5,
        ALD_OP_XOR = 4'h6,
        ALD_OP_CLR = 4'h7,
        ALD_OP_CPL = 4'h8,
        ALD_OP_SWAP = 4'h9,
        ALD_OP_RL = 4'hA,
        ALD_OP_RLC = 4'hB,
        ALD_OP_RR = 4'hC,
        ALD_OP_RRC = 4'hD
    } ald_op_t;

    typedef enum logic [2:0] {
        ALD_M_NONE = 3'h0,
        ALD_M_REG = 3'h1,
        ALD_M_DIR = 3'h2,
        ALD_M_IND = 3'h3,
        ALD_M_IMM = 3'h4,
        ALD_M_ACC = 3'h5,
        ALD_M_DIR_ACC = 3'h6,
        ALD_M_DIR_IMM = 3'h7
    } ald_mode_t;

    typedef enum logic [1:0] {
        ALD_S_IDLE = 2'b01,
        ALD_S_RUN = 2'b10
    } ald_state_t;

    typedef struct packed {
        logic start;
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
    } ald_fetch_t;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] src;
        logic cy;
        logic ac;
        logic ov;
    } ald_operand_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic legal;
        ald_op_t op;
        ald_mode_t mode;
        logic [1:0] len;
        logic [2:0] cycles;
        logic [2:0] reg_idx;
        logic ptr_sel;
        logic [7:0] dir_addr;
        logic [7:0] result;
        logic cy;
        logic ac;
        logic ov;
        logic wr_acc;
        logic wr_dir;
    } ald_result_t;

endpackage : ald_pkg

/* File: verilog/ald_alu.sv */
module ald_alu
    import ald_pkg::*;
(
    input wire ald_pkg::ald_op_t op,
    input wire logic [7:0] x,
    input wire logic [7:0] y,
    input wire logic cy_in,
    input wire logic ac_in,
    input wire logic ov_in,
    output logic [7:0] res,
    output logic cy,
    output logic ac,
    output logic ov
);
    import ald_pkg::*;

    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] mid;
    logic cin;

    always_comb begin
        full = 9'h000;
        low = 5'h00;
        mid = 8'h00;
        cin = (op == ALD_OP_ADD) ? 1'b0 : cy_in;
        res = x;
        cy = cy_in;
        ac = ac_in;
        ov = ov_in;
        unique case (op)
            ALD_OP_ADD, ALD_OP_ADDC: begin
                full = {1'b0, x} + {1'b0, y} + {8'h00, cin};
                low = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
                mid = {1'b0, x[6:0]} + {1'b0, y[6:0]} + {7'h00, cin};
                res = full[7:0];
                cy = full[8];
                ac = low[4];
                // Signed overflow: carry into bit 7 differs from carry out
                ov = full[8] ^ mid[7];
            end
            ALD_OP_SUBB: begin
                full = {1'b0, x} - {1'b0, y} - {8'h00, cin};
                low = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
                mid = {1'b0, x[6:0]} - {1'b0, y[6:0]} - {7'h00, cin};
                res = full[7:0];
                cy = full[8];
                ac = low[4];
                ov = full[8] ^ mid[7];
            end
            ALD_OP_AND: res = x & y;
            ALD_OP_OR: res = x | y;
            ALD_OP_XOR: res = x ^ y;
            ALD_OP_CLR: res = 8'h00;
            ALD_OP_CPL: res = ~x;
            ALD_OP_SWAP: res = {x[3:0], x[7:4]};
            ALD_OP_RL: res = {x[6:0], x[7]};
            ALD_OP_RR: res = {x[0], x[7:1]};
            ALD_OP_RLC: begin
                res = {x[6:0], cy_in};
                cy = x[7];
            end
            ALD_OP_RRC: begin
                res = {cy_in, x[7:1]};
                cy = x[0];
            end
            ALD_OP_NONE: res = x;
            default: res = x;
        endcase
    end
endmodule : ald_alu

/* File: verilog/ald_decoder.sv */
module ald_decoder
    import ald_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire ald_pkg::ald_fetch_t fetch,
    input wire ald_pkg::ald_operand_t opnd,
    output ald_pkg::ald_result_t dec
);
    import ald_pkg::*;

    typedef struct packed {
        ald_state_t state;
        logic [2:0] cnt;
        logic [7:0] imm;
        ald_result_t out;
    } ald_regs_t;

    ald_regs_t regs_r;
    ald_regs_t regs_nxt;
    ald_result_t d;
    logic [3:0] hi;
    logic [3:0] lo;
    logic two_op;
    logic logic_grp;
    logic [7:0] alu_x;
    logic [7:0] alu_y;
    logic [7:0] alu_res;
    logic alu_cy;
    logic alu_ac;
    logic alu_ov;

    ////////////////////////////////////////////////////////////////////////
    // Opcode decode
    always_comb begin
        hi = fetch.opcode[7:4];
        lo = fetch.opcode[3:0];
        d = '0;
        d.op = ALD_OP_NONE;
        d.mode = ALD_M_NONE;
        d.len = LEN_ONE;
        d.cycles = CYC_SHORT;
        d.dir_addr = fetch.byte1;
        d.reg_idx = fetch.opcode[2:0];
        d.ptr_sel = fetch.opcode[0];
        two_op = 1'b1;
        logic_grp = 1'b0;
        unique case (hi)
            HI_ADD: d.op = ALD_OP_ADD;
            HI_ADDC: d.op = ALD_OP_ADDC;
            HI_SUBB: d.op = ALD_OP_SUBB;
            HI_ANL: begin
                d.op = ALD_OP_AND;
                logic_grp = 1'b1;
            end
            HI_ORL: begin
                d.op = ALD_OP_OR;
                logic_grp = 1'b1;
            end
            HI_XRL: begin
                d.op = ALD_OP_XOR;
                logic_grp = 1'b1;
            end
            default: two_op = 1'b0;
        endcase
        if (two_op) begin
            d.legal = 1'b1;
            if (fetch.opcode[3]) begin
                d.mode = ALD_M_REG;
            end else begin
                unique case (lo)
                    LO_DIR: begin
                        d.mode = ALD_M_DIR;
                        d.len = LEN_TWO;
                    end
                    LO_IND0, LO_IND1: d.mode = ALD_M_IND;
                    LO_IMM: begin
                        d.mode = ALD_M_IMM;
                        d.len = LEN_TWO;
                    end
                    LO_DIR_ACC: begin
                        d.mode = ALD_M_DIR_ACC;
                        d.len = LEN_TWO;
                        d.legal = logic_grp;
                    end
                    LO_DIR_IMM: begin
                        d.mode = ALD_M_DIR_IMM;
                        d.len = LEN_THREE;
                        d.cycles = CYC_LONG;
                        d.legal = logic_grp;
                    end
                    default: d.legal = 1'b0;
                endcase
            end
        end
        if (!two_op || !d.legal) begin
            // Other opcodes: single-byte accumulator ops decode here, the rest are flagged illegal
            d.legal = 1'b1;
            d.mode = ALD_M_ACC;
            d.len = LEN_ONE;
            d.cycles = CYC_SHORT;
            unique case (fetch.opcode)
                OPC_CLR: d.op = ALD_OP_CLR;
                OPC_CPL: d.op = ALD_OP_CPL;
                OPC_SWAP: d.op = ALD_OP_SWAP;
                OPC_RL: d.op = ALD_OP_RL;
                OPC_RLC: d.op = ALD_OP_RLC;
                OPC_RR: d.op = ALD_OP_RR;
                OPC_RRC: d.op = ALD_OP_RRC;
                default: begin
                    d.op = ALD_OP_NONE;
                    d.mode = ALD_M_NONE;
                    d.legal = 1'b0;
                end
            endcase
        end
        d.wr_dir = d.legal && (d.mode == ALD_M_DIR_ACC ||
                               d.mode == ALD_M_DIR_IMM);
        d.wr_acc = d.legal && !d.wr_dir;
    end

    ////////////////////////////////////////////////////////////////////////
    // Operand steering for the execute step
    always_comb begin
        alu_x = opnd.acc;
        alu_y = opnd.src;
        unique case (regs_r.out.mode)
            ALD_M_IMM: alu_y = regs_r.imm;
            ALD_M_DIR_ACC: begin
                alu_x = opnd.src;
                alu_y = opnd.acc;
            end
            ALD_M_DIR_IMM: begin
                alu_x = opnd.src;
                alu_y = regs_r.imm;
            end
            default: alu_y = opnd.src;
        endcase
    end

    ald_alu u_alu (
        .op(regs_r.out.op),
        .x(alu_x),
        .y(alu_y),
        .cy_in(opnd.cy),
        .ac_in(opnd.ac),
        .ov_in(opnd.ov),
        .res(alu_res),
        .cy(alu_cy),
        .ac(alu_ac),
        .ov(alu_ov)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: accept, count the cycles, then deliver the result
    always_comb begin
        regs_nxt = regs_r;
        regs_nxt.out.done = 1'b0;
        unique case (regs_r.state)
            ALD_S_IDLE: begin
                if (fetch.start) begin
                    regs_nxt.out = d;
                    regs_nxt.out.busy = 1'b1;
                    regs_nxt.out.done = 1'b0;
                    regs_nxt.out.result = opnd.acc;
                    regs_nxt.out.cy = opnd.cy;
                    regs_nxt.out.ac = opnd.ac;
                    regs_nxt.out.ov = opnd.ov;
                    // Immediate sits in the last fetched byte
                    regs_nxt.imm = (d.mode == ALD_M_DIR_IMM) ?
                                   fetch.byte2 : fetch.byte1;
                    regs_nxt.cnt = d.cycles - CNT_LAST;
                    regs_nxt.state = ALD_S_RUN;
                end
            end
            ALD_S_RUN: begin
                if (regs_r.cnt == CNT_LAST) begin
                    regs_nxt.state = ALD_S_IDLE;
                    regs_nxt.out.busy = 1'b0;
                    regs_nxt.out.done = 1'b1;
                    if (regs_r.out.legal) begin
                        regs_nxt.out.result = alu_res;
                        regs_nxt.out.cy = alu_cy;
                        regs_nxt.out.ac = alu_ac;
                        regs_nxt.out.ov = alu_ov;
                    end
                end else begin
                    regs_nxt.cnt = regs_r.cnt - CNT_LAST;
                end
            end
            default: regs_nxt.state = ALD_S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            regs_r <= '0;
            regs_r.state <= ALD_S_IDLE;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    assign dec = regs_r.out;
endmodule : ald_decoder

/* File: dv/ald_decoder_monitor.sv */
module ald_decoder_monitor (
    input wire logic core_clk,
    input wire logic nrst,
    input wire ald_pkg::ald_fetch_t fetch,
    input wire ald_pkg::ald_operand_t opnd,
    input wire ald_pkg::ald_result_t dec
);
    timeunit 1ns;
    timeprecision 1ps;
    import ald_pkg::*;
    logic take;
    logic lng;
    logic [2:0] opc_reg;
    logic opc_ptr;
    assign opc_reg = fetch.opcode[2:0];
    assign opc_ptr = fetch.opcode[0];
    assign take = fetch.start && !dec.busy;
    assign lng = fetch.opcode inside {8'h53, 8'h43, 8'h63};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////
    sequence s_busy3;
        (dec.busy && !dec.done) [*3];
    endsequence
    sequence s_finish;
        dec.done && !dec.busy;
    endsequence
    short_done_a: assert property (
        take && !lng |=> dec.busy ##1 s_finish)
        else $error("short op did not finish in two cycles");
    long_done_a: assert property (
        take && lng |=> s_busy3 ##1 s_finish)
        else $error("long op did not finish in four cycles");
    long_shape_a: assert property (take && lng |=>
        dec.len == LEN_THREE && dec.cycles == CYC_LONG)
        else $error("long op length or cycles wrong");
    done_pulse_a: assert property (dec.done |=> !dec.done)
        else $error("done wider than one cycle");
    operand_sel_a: assert property (take |=>
        dec.reg_idx == $past(opc_reg) &&
        dec.ptr_sel == $past(opc_ptr))
        else $error("register or pointer select wrong");
    dir_addr_a: assert property (
        take |=> dec.dir_addr == $past(fetch.byte1))
        else $error("direct address not taken from second byte");
    logic_carry_a: assert property (dec.done &&
        dec.op inside {ALD_OP_AND, ALD_OP_OR, ALD_OP_XOR} |->
        dec.cy == $past(opnd.cy))
        else $error("logical op changed carry");
    add_imm_a: assert property (dec.done && dec.op == ALD_OP_ADD &&
        dec.mode == ALD_M_IMM |->
        dec.result == 8'($past(opnd.acc) + dec.dir_addr))
        else $error("add immediate result wrong");
    clr_zero_a: assert property (dec.done && dec.op == ALD_OP_CLR |->
        dec.result == 8'h00 && dec.wr_acc)
        else $error("clear did not write zero");
endmodule : ald_decoder_monitor

bind ald_decoder ald_decoder_monitor i_mon (.core_clk(core_clk),
    .nrst(nrst), .fetch(fetch), .opnd(opnd), .dec(dec));

/* File: dv/arith_logic_instr_decode_bench.sv */
module arith_logic_instr_decode_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ald_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    ald_fetch_t fetch = '0;
    ald_operand_t opnd = '{8'h5A, 8'h3C, 1'b1, 1'b0, 1'b0};
    ald_result_t dec;
    int fails = 0;
    int check_count = 0;
    always #10 core_clk = ~core_clk;
    ald_decoder i_dut (.core_clk(core_clk), .nrst(nrst), .fetch(fetch),
        .opnd(opnd), .dec(dec));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask : chk
    // Operand source equals byte1 so every mode but direct,#data (byte2) gives one expected value
    task automatic run(input logic [7:0] op, output int n);
        @(negedge core_clk);
        fetch = '{1'b1, op, 8'h3C, 8'h0F};
        @(negedge core_clk);
        fetch.start = 1'b0;
        n = 1;
        while (dec.done !== 1'b1 && n < 9) begin
            @(negedge core_clk);
            n++;
        end
    endtask : run
    task automatic t_groups();
        logic [3:0] hi [6] = '{4'h2, 4'h3, 4'h9, 4'h5, 4'h4, 4'h6};
        logic [7:0] ra [6] = '{8'h96, 8'h97, 8'h1D, 8'h18, 8'h7E, 8'h66};
        logic [7:0] ri [6] = '{8'h00, 8'h00, 8'h00, 8'h0C, 8'h3F, 8'h33};
        logic [2:0] fl [6] = '{3'h3, 3'h3, 3'h2, 3'h4, 3'h4, 3'h4};
        ald_mode_t m;
        logic [7:0] o;
        int n;
        for (int g = 0; g < 6; g++) begin
            for (int lo = 2; lo < 16; lo++) begin
                if (g < 3 && lo < 4) continue;
                o = {hi[g], 4'(lo)};
                m = lo > 7 ? ALD_M_REG : lo > 5 ? ALD_M_IND :
                    lo == 5 ? ALD_M_DIR : lo == 4 ? ALD_M_IMM :
                    lo == 3 ? ALD_M_DIR_IMM : ALD_M_DIR_ACC;
                run(o, n);
                chk("cycles", lo == 3 ? 8'h04 : 8'h02, 8'(n));
                chk("op", 8'(g + 1), {4'h0, dec.op});
                chk("mode_len_cyc", {m, lo > 5 ? LEN_ONE : lo == 3 ?
                    LEN_THREE : LEN_TWO, lo == 3 ? CYC_LONG : CYC_SHORT},
                    {dec.mode, dec.len, dec.cycles});
                chk("result", lo == 3 ? ri[g] : ra[g], dec.result);
                chk("flags", {3'h0, fl[g], lo < 4, lo > 3}, {3'h0, dec.cy,
                    dec.ac, dec.ov, dec.wr_dir, dec.wr_acc});
                chk("index", {4'h1, o[2:0], o[0]}, {3'h0, dec.legal,
                    dec.reg_idx, dec.ptr_sel});
            end
        end
    endtask : t_groups
    task automatic t_accops();
        logic [7:0] oc [7] = '{8'hE4, 8'hF4, 8'hC4, 8'h23, 8'h33, 8'h03,
            8'h13};
        logic [7:0] rs [7] = '{8'h00, 8'hA5, 8'hA5, 8'hB4, 8'hB5, 8'h2D,
            8'hAD};
        int n;
        for (int i = 0; i < 7; i++) begin
            run(oc[i], n);
            chk("cycles", 8'h02, 8'(n));
            chk("op", 8'(i + 7), {4'h0, dec.op});
            chk("mode_len_cyc", {ALD_M_ACC, LEN_ONE, CYC_SHORT},
                {dec.mode, dec.len, dec.cycles});
            chk("result", rs[i], dec.result);
            chk("carry", {7'h0, !(i == 4 || i == 6)},
                {7'h0, dec.cy});
        end
    endtask : t_accops
    task automatic t_illegal();
        logic [7:0] oc [3] = '{8'h22, 8'h92, 8'h00};
        int n;
        for (int i = 0; i < 3; i++) begin
            run(oc[i], n);
            chk("cycles", 8'h02, 8'(n));
            chk("result", 8'h5A, dec.result);
            chk("flags", 8'h20, {2'h0, dec.cy, dec.ac, dec.ov, dec.wr_dir,
                dec.wr_acc, dec.legal});
        end
    endtask : t_illegal
    // Start stays high: the opcode swap while busy must be ignored
    task automatic t_b2b();
        int n;
        @(negedge core_clk);
        fetch = '{1'b1, 8'h53, 8'h3C, 8'h0F};
        @(negedge core_clk);
        fetch.opcode = 8'h24;
        n = 1;
        while (dec.done !== 1'b1 && n < 9) begin
            @(negedge core_clk);
            n++;
        end
        chk("long_cycles", 8'h04, 8'(n));
        chk("busy_op", {4'h0, ALD_OP_AND}, {4'h0, dec.op});
        chk("long_result", 8'h0C, dec.result);
        @(negedge core_clk);
        fetch.start = 1'b0;
        @(negedge core_clk);
        chk("next_done", 8'h01, {7'h0, dec.done});
        chk("next_result", 8'h96, dec.result);
    endtask : t_b2b
    task automatic t_reset();
        int n;
        @(negedge core_clk);
        fetch = '{1'b1, 8'h63, 8'h3C, 8'h0F};
        @(negedge core_clk);
        fetch.start = 1'b0;
        nrst = 1'b0;
        #1;
        chk("reset_state", 8'h00, {6'h0, dec.busy, dec.done});
        @(negedge core_clk);
        nrst = 1'b1;
        run(8'h64, n);
        chk("after_reset", 8'h66, dec.result);
    endtask : t_reset
    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    // About seventeen times the expected run length
    initial begin
        #100000;
        fails++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        nrst = 1'b1;
        t_groups();
        t_accops();
        t_illegal();
        t_b2b();
        t_reset();
        print_verdict();
    end
endmodule : arith_logic_instr_decode_bench
